// ---- piopc_top.sv ----
// Per-pin control of one eight-pin general-purpose I/O port
//
// Summary of operation
// - Reset clears direction, all pins but output-only pin 2 become inputs
// - Reset sets slew, clears drive and pull
// - Enabled shared peripheral overrides general-purpose function
// - LCD pins full drive only at supply 11
// - Direction enables output and selects read source
// - Input buffer on unless analog or output-only
// - Shared digital function drives output enable
// - Analog function disables input and output buffers
// - Input read with buffer off returns zero
// - Analog wins over alternate digital function
// - Each pin has its own pull enable
// - Pull off in output, except LCD open drain
// - Pull forced off under analog or peripheral
// - Slew bit ignored while pin is input
// - Drive select bit chooses high drive
// - Partial power-down stop holds pin latches
// - LCD pin drive mode kept across stop while the LCD keeps running in stop
// - Powered-logic stop keeps all I/O state
// - Acknowledge write clears recovery flag
// - Data write latches all bits; outputs drive them
// - Direction write cannot affect output-only pin
`timescale 1ns/100ps

module piopc_top
	import piopc_pkg::*;
(
	input  wire logic        I_CLOCK,        // Bus clock, 100 MHz
	input  wire logic        I_RST,          // Asynchronous reset, active high
	input  wire logic        i_data_wr,      // Port data write strobe
	input  wire logic [7:0]  i_data_wdata,   // Port data write value
	input  wire logic        i_dir_wr,       // Direction write strobe
	input  wire logic [7:0]  i_dir_wdata,    // Direction write value
	input  wire logic        i_pull_wr,      // Pull enable write strobe
	input  wire logic [7:0]  i_pull_wdata,   // Pull enable write value
	input  wire logic        i_slew_wr,      // Slew limit write strobe
	input  wire logic [7:0]  i_slew_wdata,   // Slew limit write value
	input  wire logic        i_drive_wr,     // High drive write strobe
	input  wire logic [7:0]  i_drive_wdata,  // High drive write value
	input  wire logic [7:0]  i_periph_en,    // Shared digital function enable per pin
	input  wire logic [7:0]  i_periph_oe,    // Shared function output enable, high drives
	input  wire logic [7:0]  i_periph_do,    // Shared function output value
	input  wire logic [7:0]  i_analog_en,    // Analog function enable per pin
	input  wire logic [1:0]  i_lcd_supply,   // LCD supply select
	input  wire logic        i_full_drive,   // LCD full drive enable
	input  wire logic        i_lcd_reg_en,   // LCD regulator enable
	input  wire logic        i_lcd_in_stop,  // LCD keeps running in stop modes
	input  wire logic        i_partial_powerdown_stop,        // Partial power-down stop active
	input  wire logic        i_powered_logic_stop,        // Powered-logic stop active
	input  wire logic        i_pd_ack,       // Power-down acknowledge write of one
	input  wire logic [7:0]  i_pin,          // Pin input levels
	output logic      [7:0]  o_pin,          // Pin output levels
	output logic      [7:0]  o_pin_oe_n,     // Pin output enable, low drives
	output logic      [7:0]  o_in_buf_en,    // Input buffer enable
	output logic      [7:0]  o_pull_on,      // Internal pull device on
	output logic      [7:0]  o_slew_on,      // Slew limiting active
	output logic      [7:0]  o_high_drive,   // High drive strength active
	output logic      [7:0]  o_open_drain,   // Pin in open-drain mode
	output logic      [7:0]  o_data_rd,      // Port data read value
	output logic      [7:0]  o_dir_rd,       // Direction register value
	output logic      [7:0]  o_pull_rd,      // Pull enable register value
	output logic      [7:0]  o_slew_rd,      // Slew limit register value
	output logic      [7:0]  o_drive_rd,     // High drive register value
	output logic             o_pd_flag,      // Partial power-down recovery flag
	output piopc_mode_t      o_mode          // Current stop state
);

	// Control registers
	piopc_byte_t data_q;    // Port data latch, one bit per pin
	piopc_byte_t dir_q;
	piopc_byte_t pull_q;
	piopc_byte_t slew_q;
	piopc_byte_t drive_q;
	logic        lcd_od_q;
	logic        partial_powerdown_stop_q;
	logic        pd_flag_q;
	piopc_mode_t mode_q;

	// Pin input synchroniser and filtered level
	piopc_byte_t pin_s1_q;
	piopc_byte_t pin_s2_q;
	piopc_byte_t pin_s3_q;
	piopc_byte_t pin_lvl_q;

	// Registered pin controls and read data
	piopc_byte_t pin_q;
	piopc_byte_t pin_oe_n_q;
	piopc_byte_t in_buf_q;
	piopc_byte_t pull_on_q;
	piopc_byte_t slew_on_q;
	piopc_byte_t hdrive_q;
	piopc_byte_t od_q;
	piopc_byte_t rd_q;

	// Next-value and decode wires
	logic        wr_ok;
	logic        lcd_od_d;
	logic        pd_flag_d;
	logic        wake2;
	piopc_mode_t mode_d;
	piopc_byte_t eff_dir;
	piopc_byte_t analog;
	piopc_byte_t periph;
	piopc_byte_t gpio;
	piopc_byte_t in_buf_d;
	piopc_byte_t drive_req;
	piopc_byte_t drv_val;
	piopc_byte_t od_pins;
	piopc_byte_t oe_d;
	piopc_byte_t pin_d;
	piopc_byte_t pull_on_d;
	piopc_byte_t slew_on_d;
	piopc_byte_t hdrive_d;
	piopc_byte_t rd_d;

	// Writes are frozen while the port is held in partial power-down
	assign wr_ok = ~i_partial_powerdown_stop;

	// Ownership: analog above shared digital above general purpose
	assign analog = i_analog_en;
	assign periph = i_periph_en & ~i_analog_en;
	assign gpio   = ~(i_analog_en | i_periph_en);

	// Output-only pins are outputs whatever direction was written
	assign eff_dir = dir_q | PIOPC_OUT_ONLY_MASK;

	// Input buffer on except for analog and output-only pins
	assign in_buf_d = ~analog & ~PIOPC_OUT_ONLY_MASK;

	// Who requests drive on each pin
	assign drive_req = (periph & i_periph_oe) | (gpio & eff_dir);
	assign drv_val   = (periph & i_periph_do) | (~periph & data_q);

	// LCD pins use full drive only in the full supply setting
	assign lcd_od_d = ~((i_lcd_supply == PIOPC_SUPPLY_FULL) && i_full_drive
		&& !i_lcd_reg_en);
	assign od_pins  = PIOPC_LCD_MASK & {PIOPC_PINS{lcd_od_q}};

	// Open drain only pulls low; high is left to the pull resistor
	assign oe_d  = ~analog & drive_req & ~(od_pins & drv_val);
	assign pin_d = drv_val & ~od_pins;

	// Pull: own bit, off when driven unless LCD open drain, off when owned
	assign pull_on_d = pull_q & gpio & (~eff_dir | od_pins);

	// Slew and drive strength act only on driven pins
	assign slew_on_d = slew_q & oe_d;
	assign hdrive_d  = drive_q & oe_d;

	// Read source: latch for outputs, pin for inputs, zero if buffer off
	assign rd_d = (eff_dir & data_q) | (~eff_dir & in_buf_d & pin_lvl_q);

	// Recovery flag set on wake from partial power-down; the set wins
	assign wake2     = partial_powerdown_stop_q & ~i_partial_powerdown_stop;
	assign pd_flag_d = wake2 | (pd_flag_q & ~i_pd_ack);

	// Stop state report
	assign mode_d = i_partial_powerdown_stop ? PIOPC_PARTIAL_POWERDOWN_STOP : (i_powered_logic_stop ? PIOPC_POWERED_LOGIC_STOP : PIOPC_RUN);

	// Software-visible control registers
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			data_q  <= PIOPC_DATA_RST;
			dir_q   <= PIOPC_DIR_RST;
			pull_q  <= PIOPC_PULL_RST;
			slew_q  <= PIOPC_SLEW_RST;
			drive_q <= PIOPC_DRIVE_RST;
		end
		else if (wr_ok)
		begin
			if (i_data_wr)
				data_q  <= i_data_wdata;
			if (i_dir_wr)
				dir_q   <= i_dir_wdata;
			if (i_pull_wr)
				pull_q  <= i_pull_wdata;
			if (i_slew_wr)
				slew_q  <= i_slew_wdata;
			if (i_drive_wr)
				drive_q <= i_drive_wdata;
		end
	end

	// LCD drive mode, held during stop when the LCD keeps running
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
			lcd_od_q <= 1'b1;
		else if (!((i_partial_powerdown_stop || i_powered_logic_stop) && i_lcd_in_stop))
			lcd_od_q <= lcd_od_d;
	end

	// Power-down tracking and recovery flag
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			partial_powerdown_stop_q   <= 1'b0;
			pd_flag_q <= 1'b0;
			mode_q    <= PIOPC_RUN;
		end
		else
		begin
			partial_powerdown_stop_q   <= i_partial_powerdown_stop;
			pd_flag_q <= pd_flag_d;
			mode_q    <= mode_d;
		end
	end

	// Three-stage pin synchroniser; level taken when stages two and three agree
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_s3_q <= 8'h00;
		end
		else
		begin
			pin_s1_q <= i_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Filtered pin level, one generate stage per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIOPC_PINS; gi++)
		begin : g_lvl
			always_ff @(posedge I_CLOCK or posedge I_RST)
			begin
				if (I_RST)
					pin_lvl_q[gi] <= 1'b0;
				else if (pin_s2_q[gi] == pin_s3_q[gi])
					pin_lvl_q[gi] <= pin_s3_q[gi];
			end
		end
	endgenerate

	// Registered pin controls; frozen in partial power-down, kept in powered_logic_stop
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pin_q      <= 8'h00;
			pin_oe_n_q <= 8'hFF;
			in_buf_q   <= 8'h00;
			pull_on_q  <= 8'h00;
			slew_on_q  <= 8'h00;
			hdrive_q   <= 8'h00;
			od_q       <= PIOPC_LCD_MASK;
		end
		else if (!i_partial_powerdown_stop)
		begin
			pin_q      <= pin_d;
			pin_oe_n_q <= ~oe_d;
			in_buf_q   <= in_buf_d;
			pull_on_q  <= pull_on_d;
			slew_on_q  <= slew_on_d;
			hdrive_q   <= hdrive_d;
			od_q       <= od_pins;
		end
	end

	// Registered port data read
	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
			rd_q <= 8'h00;
		else
			rd_q <= rd_d;
	end

	// Outputs
	assign o_pin        = pin_q;
	assign o_pin_oe_n   = pin_oe_n_q;
	assign o_in_buf_en  = in_buf_q;
	assign o_pull_on    = pull_on_q;
	assign o_slew_on    = slew_on_q;
	assign o_high_drive = hdrive_q;
	assign o_open_drain = od_q;
	assign o_data_rd    = rd_q;
	assign o_dir_rd     = dir_q;
	assign o_pull_rd    = pull_q;
	assign o_slew_rd    = slew_q;
	assign o_drive_rd   = drive_q;
	assign o_pd_flag    = pd_flag_q;
	assign o_mode       = mode_q;

	// Checks on ownership, drive, pull, reads and stop behaviour
	analog_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && i_analog_en[0]) |=> (o_pin_oe_n[0] && !o_in_buf_en[0]))
		else $error("analog pin kept a buffer");
	periph_oe_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && i_periph_en[1] && !i_analog_en[1])
		|=> (o_pin_oe_n[1] == !$past(i_periph_oe[1])))
		else $error("peripheral lost output enable");
	dir_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(dir_q[0] && !i_periph_en[0] && !i_analog_en[0] && !i_partial_powerdown_stop)
		|=> (o_data_rd[0] == $past(data_q[0]) && !o_pin_oe_n[0]))
		else $error("output pin read or drive wrong");
	zero_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!dir_q[3] && i_analog_en[3]) |=> (o_data_rd[3] == 1'b0))
		else $error("disabled input read not zero");
	pull_owned_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && (i_analog_en[6] || i_periph_en[6])) |=> !o_pull_on[6])
		else $error("pull on under peripheral");
	pull_out_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && dir_q[7] && !i_analog_en[7] && !i_periph_en[7]) |=> !o_pull_on[7])
		else $error("pull on in output mode");
	lcd_full_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && !i_powered_logic_stop && i_lcd_supply == PIOPC_SUPPLY_FULL && i_full_drive
		&& !i_lcd_reg_en) ##1 !i_partial_powerdown_stop |=> (o_open_drain[4] == 1'b0))
		else $error("lcd pin not full drive");
	od_high_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && lcd_od_q && data_q[5] && dir_q[5] && !i_periph_en[5]) |=> o_pin_oe_n[5])
		else $error("open drain drove high");
	slew_in_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		o_pin_oe_n[2] |-> (!o_slew_on[2] && !o_high_drive[2]))
		else $error("slew or drive on input pin");
	hold_partial_powerdown_stop_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		i_partial_powerdown_stop |=> ($stable(o_pin) && $stable(o_pin_oe_n) && $stable(data_q)))
		else $error("pin state moved in partial_powerdown_stop");
	out_only_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(!i_partial_powerdown_stop && !i_analog_en[2] && !i_periph_en[2])
		|=> (!o_in_buf_en[2] && !o_pin_oe_n[2]))
		else $error("output-only pin changed");
	flag_set_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		($fell(i_partial_powerdown_stop)) |=> o_pd_flag ##1 (o_pd_flag || $past(i_pd_ack)))
		else $error("recovery flag not set on wake");
	flag_clr_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(i_pd_ack && !wake2) |=> !o_pd_flag)
		else $error("acknowledge did not clear flag");

	// Main scenarios
	cov_wake_c:   cover property (@(posedge I_CLOCK) disable iff (I_RST)
		i_partial_powerdown_stop ##1 !i_partial_powerdown_stop ##[1:20] i_pd_ack);
	cov_od_c:     cover property (@(posedge I_CLOCK) disable iff (I_RST)
		o_open_drain[4] && !o_pin_oe_n[4] && o_pull_on[4]);
	cov_periph_c: cover property (@(posedge I_CLOCK) disable iff (I_RST)
		i_periph_en[0] && i_periph_oe[0] ##1 !o_pin_oe_n[0]);
	cov_read_c:   cover property (@(posedge I_CLOCK) disable iff (I_RST)
		!dir_q[1] && o_data_rd[1]);

endmodule

// ---- piopc_pkg.sv ----
// Constants and types shared by the parallel I/O pin control block
package piopc_pkg;

	// Port geometry
	localparam int unsigned PIOPC_PINS = 8;

	typedef logic [PIOPC_PINS-1:0] piopc_byte_t;

	// Reset values of the per-pin control registers
	localparam piopc_byte_t PIOPC_DATA_RST  = 8'h00;
	localparam piopc_byte_t PIOPC_DIR_RST   = 8'h00;
	localparam piopc_byte_t PIOPC_PULL_RST  = 8'h00;
	localparam piopc_byte_t PIOPC_SLEW_RST  = 8'hFF;
	localparam piopc_byte_t PIOPC_DRIVE_RST = 8'h00;

	// Pins without an input path and pins shared with the LCD
	localparam piopc_byte_t PIOPC_OUT_ONLY_MASK = 8'h04;
	localparam piopc_byte_t PIOPC_LCD_MASK      = 8'h30;

	// LCD supply setting that allows full complementary drive
	localparam logic [1:0] PIOPC_SUPPLY_FULL = 2'h3;

	// Stop state as seen by the block
	typedef enum logic [1:0]
	{
		PIOPC_RUN   = 2'b00,
		PIOPC_PARTIAL_POWERDOWN_STOP = 2'b01,
		PIOPC_POWERED_LOGIC_STOP = 2'b10
	} piopc_mode_t;

endpackage

// ---- piopc_pins.sv ----
// Model of the board circuitry that sits on the port pins
`timescale 1ns/100ps

module piopc_pins
	import piopc_pkg::*;
(
	input  wire logic        i_clk,     // Bus clock
	input  wire piopc_byte_t i_drive,   // Device drive value
	input  wire piopc_byte_t i_oe_n,    // Device output enable, low drives
	input  wire piopc_byte_t i_pull_on, // Device internal pull active
	input  wire piopc_byte_t i_ext_en,  // Board driver enable
	input  wire piopc_byte_t i_ext_val, // Board driver value
	output piopc_byte_t      o_level    // Resolved pin level
);
	piopc_byte_t float_q = 8'h55;

	// A line that nobody drives or pulls wanders every cycle
	always @(posedge i_clk)
		float_q <= ~float_q;

	// Device drive wins, then the board driver, then the pull
	always_comb
		for (int n = 0; n < PIOPC_PINS; n++)
			o_level[n] = !i_oe_n[n] ? i_drive[n] : i_ext_en[n] ? i_ext_val[n]
				: i_pull_on[n] ? 1'b1 : float_q[n];
endmodule

// ---- parallel_io_pin_control_tb.sv ----
// Self-checking testbench for the parallel I/O pin control block
`timescale 1ns/100ps

module parallel_io_pin_control_tb
	import piopc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  wr_s = 5'h00;
	piopc_byte_t wd = 8'h00;
	piopc_byte_t p_en = 8'h00;
	piopc_byte_t p_oe = 8'h00;
	piopc_byte_t p_do = 8'h00;
	piopc_byte_t a_en = 8'h00;
	piopc_byte_t ext_en = 8'hFF;
	piopc_byte_t ext_v = 8'h38;
	logic [1:0]  sup = 2'h3;
	logic        fd = 1'b1;
	logic        rg = 1'b0;
	logic        s2 = 1'b0;
	logic        s3 = 1'b0;
	logic        ack = 1'b0;
	logic        lis = 1'b1;
	piopc_byte_t lvl, pin, oe_n, inb, pull_on, slew_on, hdrv, od, rd;
	piopc_byte_t dir_rd, pull_rd, slew_rd, drv_rd;
	logic        pd;
	piopc_mode_t mode;
	int          failures = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          k;
	logic [4:0]  tbl [4] = '{5'h1E, 5'h18, 5'h14, 5'h1D};

	always #5 clk = ~clk;

	piopc_top piopc_top_i (.I_CLOCK(clk), .I_RST(rst),
		.i_data_wr(wr_s[0]), .i_data_wdata(wd), .i_dir_wr(wr_s[1]), .i_dir_wdata(wd),
		.i_pull_wr(wr_s[2]), .i_pull_wdata(wd), .i_slew_wr(wr_s[3]), .i_slew_wdata(wd),
		.i_drive_wr(wr_s[4]), .i_drive_wdata(wd), .i_periph_en(p_en), .i_periph_oe(p_oe),
		.i_periph_do(p_do), .i_analog_en(a_en), .i_lcd_supply(sup), .i_full_drive(fd),
		.i_lcd_reg_en(rg), .i_lcd_in_stop(lis), .i_partial_powerdown_stop(s2), .i_powered_logic_stop(s3), .i_pd_ack(ack),
		.i_pin(lvl), .o_pin(pin), .o_pin_oe_n(oe_n), .o_in_buf_en(inb), .o_pull_on(pull_on),
		.o_slew_on(slew_on), .o_high_drive(hdrv), .o_open_drain(od), .o_data_rd(rd),
		.o_dir_rd(dir_rd), .o_pull_rd(pull_rd), .o_slew_rd(slew_rd), .o_drive_rd(drv_rd),
		.o_pd_flag(pd), .o_mode(mode));

	piopc_pins piopc_pins_i (.i_clk(clk), .i_drive(pin), .i_oe_n(oe_n), .i_pull_on(pull_on),
		.i_ext_en(ext_en), .i_ext_val(ext_v), .o_level(lvl));

	// Compare one value and count the result
	task automatic check(input string name, input piopc_byte_t seen, input piopc_byte_t exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One write strobe: 0 data, 1 direction, 2 pull, 3 slew, 4 drive
	task automatic wr(input int s, input piopc_byte_t v);
		@(negedge clk);
		wr_s[s] = 1'b1;
		wd = v;
		@(negedge clk);
		wr_s = 5'h00;
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			wrap_up;
		end
	end

	initial
	begin
		settle(8);
		rst = 1'b0;
		settle(3);
		check("dir_rd", dir_rd, 8'h00);
		check("oe_n", oe_n, 8'hFB);
		check("slew_rd", slew_rd, 8'hFF);
		check("drv_rd", drv_rd, 8'h00);
		check("pull_rd", pull_rd, 8'h00);
		check("inb", inb, 8'hFB);
		check("pd", {7'h00, pd}, 8'h00);
		$display("Test reset done");
		// Data goes in before the direction turns to output
		wr(0, 8'hA5);
		wr(1, 8'hFF);
		settle(6);
		check("pin", pin, 8'hA5);
		check("oe_n", oe_n, 8'h00);
		check("rd", rd, 8'hA5);
		check("slew_on", slew_on, 8'hFF);
		wr(4, 8'h0F);
		wr(1, 8'h00);
		settle(6);
		check("dir_rd", dir_rd, 8'h00);
		check("oe_n", oe_n, 8'hFB);
		check("hdrv", hdrv, 8'h04);
		check("slew_on", slew_on, 8'h04);
		check("rd", rd, 8'h3C);
		$display("Test direction done");
		wr(2, 8'hFF);
		settle(3);
		check("pull_on", pull_on, 8'hFB);
		wr(1, 8'hFF);
		settle(3);
		check("pull_on", pull_on, 8'h00);
		// Supply, full drive, regulator against open-drain mask
		for (k = 0; k < 4; k++)
		begin
			{sup, fd, rg} = tbl[k][4:1];
			settle(3);
			check("od", od, tbl[k][0] ? 8'h00 : 8'h30);
		end
		sup = 2'h0;
		settle(3);
		check("oe_n", oe_n, 8'h20);
		check("pin", pin, 8'h85);
		check("pull_on", pull_on, 8'h30);
		sup = 2'h3;
		$display("Test pull and drive done");
		wr(1, 8'h00);
		p_en = 8'h43;
		p_oe = 8'h01;
		p_do = 8'h01;
		ext_en = 8'hFE;
		settle(6);
		check("oe_n", oe_n, 8'hFA);
		check("pin", pin & 8'h05, 8'h05);
		check("pull_on", pull_on, 8'hB8);
		check("rd", rd, 8'h3D);
		a_en = 8'h09;
		settle(6);
		check("oe_n", oe_n, 8'hFB);
		check("inb", inb, 8'hF2);
		check("rd", rd, 8'h34);
		{p_en, a_en, ext_en} = {8'h00, 8'h00, 8'hFF};
		$display("Test ownership done");
		wr(1, 8'hFF);
		settle(2);
		s2 = 1'b1;
		settle(2);
		check("mode", {6'h00, mode}, 8'h01);
		wr(1, 8'h00);
		a_en = 8'hFF;
		settle(3);
		check("oe_n", oe_n, 8'h00);
		{s2, a_en} = {1'b0, 8'h00};
		settle(2);
		// Recovery flag is looked at before any further access
		check("pd", {7'h00, pd}, 8'h01);
		check("dir_rd", dir_rd, 8'hFF);
		ack = 1'b1;
		settle(1);
		ack = 1'b0;
		settle(2);
		check("pd", {7'h00, pd}, 8'h00);
		s3 = 1'b1;
		sup = 2'h0;
		wr(0, 8'h5A);
		settle(3);
		check("mode", {6'h00, mode}, 8'h02);
		check("od", od, 8'h00);
		check("pin", pin, 8'h5A);
		s3 = 1'b0;
		settle(3);
		check("od", od, 8'h30);
		check("pd", {7'h00, pd}, 8'h00);
		// LCD not kept running: drive mode follows the supply in stop
		lis = 1'b0;
		{s3, sup} = {1'b1, 2'h3};
		settle(3);
		check("od", od, 8'h00);
		s3 = 1'b0;
		$display("Test stop modes done");
		wrap_up;
	end
endmodule
